/* File: core/cep_pkg.sv */
/*
  Package of the channel enable and path power register bank: register
  addresses, reset values, write masks, field positions and carriers.
  Assumes a host-side serial decoder that presents byte-wide register
  reads and writes on the device clock.
*/
package cep_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] CHAN_EN_ADDR   = 8'h76;
  localparam logic [7:0] DYN_CFG_ADDR   = 8'h77;
  localparam logic [7:0] PATH_PWR_ADDR  = 8'h78;

  // ****************************************************************
  // Reset values and writable bits
  // ****************************************************************
  localparam logic [7:0] CHAN_EN_RESET  = 8'hCC;
  localparam logic [7:0] DYN_CFG_RESET  = 8'h00;
  localparam logic [7:0] PATH_PWR_RESET = 8'h00;
  localparam logic [7:0] CHAN_EN_WMASK  = 8'hFF;
  localparam logic [7:0] DYN_CFG_WMASK  = 8'hFB;
  localparam logic [7:0] PATH_PWR_WMASK = 8'hEE;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned REC_EN_MSB     = 7;
  localparam int unsigned REC_EN_LSB     = 4;
  localparam int unsigned PLAY_EN_MSB    = 3;
  localparam int unsigned PLAY_EN_LSB    = 0;
  localparam int unsigned REC_DYN_BIT    = 7;
  localparam int unsigned REC_WIDTH_BIT  = 6;
  localparam int unsigned PLAY_DYN_BIT   = 5;
  localparam int unsigned PLAY_WIDTH_BIT = 4;
  localparam int unsigned SPLIT_CLK_BIT  = 3;
  localparam int unsigned REC_SWAP_BIT   = 1;
  localparam int unsigned PLAY_SWAP_BIT  = 0;
  localparam int unsigned REC_UP_BIT     = 7;
  localparam int unsigned PLAY_UP_BIT    = 6;
  localparam int unsigned BIAS_UP_BIT    = 5;
  localparam int unsigned ULTRA_BIT      = 3;
  localparam int unsigned VOICE_BIT      = 2;
  localparam int unsigned ULTRA2_BIT     = 1;

  // ****************************************************************
  // Dynamic switching channel masks, index 0 is channel 1
  // ****************************************************************
  localparam logic [3:0] DYN_NARROW_MASK = 4'h3;
  localparam logic [3:0] DYN_WIDE_MASK   = 4'hF;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cep_reg_req_t;

  typedef struct packed {
    logic       path_up;
    logic       dyn_on;
    logic       dyn_wide;
    logic [3:0] enables;
  } cep_path_cfg_t;

endpackage

/* File: core/cep_path_power.sv */
/*
  Power sequencer for one audio path (record or playback). Turns the
  path power bit, the channel enables and the dynamic switching options
  into per-channel power-up levels, index 0 being channel 1.
  Assumes its configuration comes from registers on the same clock.
*/
`timescale 1ns/1ps

module cep_path_power (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire cep_pkg::cep_path_cfg_t cfg,
  output logic [3:0]                  ch_power
);

  typedef struct packed {
    logic [3:0] power;
    logic       was_up;
  } cep_path_state_t;

  cep_path_state_t state;
  cep_path_state_t next_state;
  logic [3:0]      dyn_mask;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state        = state;
    next_state.was_up = cfg.path_up;
    dyn_mask          = cfg.dyn_wide ? cep_pkg::DYN_WIDE_MASK
                                     : cep_pkg::DYN_NARROW_MASK;
    if (!cfg.path_up) begin
      next_state.power = 4'h0;
    end else if (!state.was_up) begin
      // Path just powered: take every enabled channel at once
      next_state.power = cfg.enables;
    end else if (cfg.dyn_on) begin
      // Channels inside the dynamic range follow their enables
      next_state.power = (cfg.enables & dyn_mask)
                       | (state.power & ~dyn_mask);
    end else begin
      next_state.power = state.power;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ch_power = state.power;

endmodule // cep_path_power

/* File: core/cep_reg_bank.sv */
/*
  Channel enable, dynamic power and path power register bank. Holds the
  three byte registers, answers host reads one cycle after the strobe and
  drives the record and playback channel power, the mic bias and the
  detection enables.
  Assumes the control port decoder delivers one-cycle read and write
  strobes with address and data, synchronous to mclk.
*/
`timescale 1ns/1ps

// Behaviour
// - Bits 7..4 enable record channels 1..4; one means enabled.
// - Bits 3..0 enable playback channels 1..4; one means enabled.
// - Channel enable register reads 0xCC after reset.
// - Without record dynamic power, no individual record changes while powered.
// - Without playback dynamic power, no individual playback changes while on.
// - Record width bit: channels 1-2 when clear, 1-4 when set.
// - Playback width bit: channels 1-2 when clear, 1-4 when set.
// - Bit 3 selects same or different modulator and microphone clocks.
// - Record swap bit exchanges record channels 1 and 2.
// - Playback swap bit exchanges playback channels 1 and 2.
// - Record path bit clear powers all down; set powers enabled ones.
// - Playback path bit clear powers all down; set powers enabled ones.
// - Power register bit 5 powers the microphone bias generator.
// - Power register bit 3 runs ultrasonic activity detection.
// - Power register bit 2 runs voice activity detection.
// - Power register bit 1 runs the second ultrasonic detector.
// - Reserved bits read zero; host writes them only as zero.
module cep_reg_bank (
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire cep_pkg::cep_reg_req_t req,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rvalid,
  output logic [3:0]                 record_power,
  output logic [3:0]                 playback_power,
  output logic                       mic_bias_power_up,
  output logic                       ultrasonic_detect_on,
  output logic                       voice_detect_on,
  output logic                       ultrasonic_second_detect_on,
  output logic                       record_pair_exchange,
  output logic                       playback_pair_exchange,
  output logic                       dynamic_split_mod_clocks
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] channel_enables;
    logic [7:0] dynamic_power_swap_config;
    logic [7:0] path_power_config;
    logic [7:0] rdata;
    logic       rvalid;
  } cep_bank_state_t;

  cep_bank_state_t        state;
  cep_bank_state_t        next_state;
  cep_pkg::cep_path_cfg_t record_cfg;
  cep_pkg::cep_path_cfg_t playback_cfg;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Reorders a nibble held channel 1 first at the top into index 0
  function automatic logic [3:0] chan_order(input logic [3:0] nib);
    chan_order = {nib[0], nib[1], nib[2], nib[3]};
  endfunction

  // Merges a write into a register, leaving read-only bits alone
  function automatic logic [7:0] merge_write(
    input logic [7:0] old_value,
    input logic [7:0] wdata,
    input logic [7:0] wmask
  );
    merge_write = (old_value & ~wmask) | (wdata & wmask);
  endfunction

  // Read decode; reserved bits and unmapped addresses read zero
  function automatic logic [7:0] read_value(
    input logic [7:0]      addr,
    input cep_bank_state_t s
  );
    case (addr)
      cep_pkg::CHAN_EN_ADDR: begin
        read_value = s.channel_enables;
      end
      cep_pkg::DYN_CFG_ADDR: begin
        read_value = s.dynamic_power_swap_config
                   & cep_pkg::DYN_CFG_WMASK;
      end
      cep_pkg::PATH_PWR_ADDR: begin
        read_value = s.path_power_config
                   & cep_pkg::PATH_PWR_WMASK;
      end
      default: begin
        read_value = cep_pkg::UNMAPPED_READ;
      end
    endcase
  endfunction

  // ****************************************************************
  // Register access
  // ****************************************************************
  always_comb begin
    next_state        = state;
    next_state.rvalid = 1'b0;
    if (req.wr) begin
      case (req.addr)
        cep_pkg::CHAN_EN_ADDR: begin
          next_state.channel_enables = merge_write(
            state.channel_enables, req.wdata,
            cep_pkg::CHAN_EN_WMASK);
        end
        cep_pkg::DYN_CFG_ADDR: begin
          next_state.dynamic_power_swap_config = merge_write(
            state.dynamic_power_swap_config, req.wdata,
            cep_pkg::DYN_CFG_WMASK);
        end
        cep_pkg::PATH_PWR_ADDR: begin
          next_state.path_power_config = merge_write(
            state.path_power_config, req.wdata,
            cep_pkg::PATH_PWR_WMASK);
        end
        default: begin
          next_state.rvalid = 1'b0;
        end
      endcase
    end
    if (req.rd) begin
      // A read in the same cycle as a write returns the old value
      next_state.rvalid = 1'b1;
      next_state.rdata  = read_value(req.addr, state);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state.channel_enables           <= cep_pkg::CHAN_EN_RESET;
      state.dynamic_power_swap_config <= cep_pkg::DYN_CFG_RESET;
      state.path_power_config         <= cep_pkg::PATH_PWR_RESET;
      state.rdata                     <= 8'h00;
      state.rvalid                    <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Path configuration
  // ****************************************************************
  always_comb begin
    record_cfg.path_up  =
      state.path_power_config[cep_pkg::REC_UP_BIT];
    record_cfg.dyn_on   =
      state.dynamic_power_swap_config[cep_pkg::REC_DYN_BIT];
    record_cfg.dyn_wide =
      state.dynamic_power_swap_config[cep_pkg::REC_WIDTH_BIT];
    record_cfg.enables  = chan_order(state.channel_enables[
      cep_pkg::REC_EN_MSB:cep_pkg::REC_EN_LSB]);
    playback_cfg.path_up  =
      state.path_power_config[cep_pkg::PLAY_UP_BIT];
    playback_cfg.dyn_on   =
      state.dynamic_power_swap_config[cep_pkg::PLAY_DYN_BIT];
    playback_cfg.dyn_wide =
      state.dynamic_power_swap_config[cep_pkg::PLAY_WIDTH_BIT];
    playback_cfg.enables  = chan_order(state.channel_enables[
      cep_pkg::PLAY_EN_MSB:cep_pkg::PLAY_EN_LSB]);
  end

  cep_path_power u_record_path (
    .mclk     (mclk),
    .nrst     (nrst),
    .cfg      (record_cfg),
    .ch_power (record_power)
  );

  cep_path_power u_playback_path (
    .mclk     (mclk),
    .nrst     (nrst),
    .cfg      (playback_cfg),
    .ch_power (playback_power)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata  = state.rdata;
  assign reg_rvalid = state.rvalid;
  assign mic_bias_power_up =
    state.path_power_config[cep_pkg::BIAS_UP_BIT];
  assign ultrasonic_detect_on =
    state.path_power_config[cep_pkg::ULTRA_BIT];
  assign voice_detect_on =
    state.path_power_config[cep_pkg::VOICE_BIT];
  assign ultrasonic_second_detect_on =
    state.path_power_config[cep_pkg::ULTRA2_BIT];
  assign record_pair_exchange =
    state.dynamic_power_swap_config[cep_pkg::REC_SWAP_BIT];
  assign playback_pair_exchange =
    state.dynamic_power_swap_config[cep_pkg::PLAY_SWAP_BIT];
  assign dynamic_split_mod_clocks =
    state.dynamic_power_swap_config[cep_pkg::SPLIT_CLK_BIT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cep_cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  logic seen_chan_write;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seen_chan_write <= 1'b0;
    end else if (req.wr && req.addr == cep_pkg::CHAN_EN_ADDR) begin
      seen_chan_write <= 1'b1;
    end
  end

  reset_enables_a: assert property (
    !seen_chan_write |-> state.channel_enables == cep_pkg::CHAN_EN_RESET)
    else $error("channel enables differ from reset value");

  record_enable_a: assert property (
    req.wr && req.addr == cep_pkg::CHAN_EN_ADDR
    |=> state.channel_enables[7:4] == $past(req.wdata[7:4]))
    else $error("record enables not stored");

  playback_enable_a: assert property (
    req.wr && req.addr == cep_pkg::CHAN_EN_ADDR
    |=> state.channel_enables[3:0] == $past(req.wdata[3:0]))
    else $error("playback enables not stored");

  record_down_a: assert property (
    !state.path_power_config[7] |=> record_power == 4'h0)
    else $error("record channel powered with path down");

  playback_down_a: assert property (
    !state.path_power_config[6] |=> playback_power == 4'h0)
    else $error("playback channel powered with path down");

  record_rise_a: assert property (
    $rose(state.path_power_config[7])
    |=> record_power == chan_order($past(state.channel_enables[7:4])))
    else $error("record power-up ignores enables");

  record_hold_a: assert property (
    state.path_power_config[7] && $past(state.path_power_config[7])
    && !state.dynamic_power_swap_config[7] |=> $stable(record_power))
    else $error("record power changed without dynamic switching");

  playback_hold_a: assert property (
    state.path_power_config[6] && $past(state.path_power_config[6])
    && !state.dynamic_power_swap_config[5] |=> $stable(playback_power))
    else $error("playback power changed without dynamic switching");

  record_narrow_a: assert property (
    state.path_power_config[7] && $past(state.path_power_config[7])
    && state.dynamic_power_swap_config[7]
    && !state.dynamic_power_swap_config[6]
    |=> record_power[3:2] == $past(record_power[3:2]))
    else $error("record channels 3-4 switched in narrow mode");

  playback_narrow_a: assert property (
    state.path_power_config[6] && $past(state.path_power_config[6])
    && state.dynamic_power_swap_config[5]
    && !state.dynamic_power_swap_config[4]
    |=> playback_power[3:2] == $past(playback_power[3:2]))
    else $error("playback channels 3-4 switched in narrow mode");

  swap_write_a: assert property (
    req.wr && req.addr == cep_pkg::DYN_CFG_ADDR
    |=> record_pair_exchange == $past(req.wdata[1])
        && playback_pair_exchange == $past(req.wdata[0]))
    else $error("swap controls not taken from write");

  bias_write_a: assert property (
    req.wr && req.addr == cep_pkg::PATH_PWR_ADDR
    |=> mic_bias_power_up == $past(req.wdata[5])
        && voice_detect_on == $past(req.wdata[2]))
    else $error("power controls not taken from write");

  reserved_read_a: assert property (
    req.rd && req.addr == cep_pkg::PATH_PWR_ADDR
    |=> reg_rvalid && reg_rdata[4] == 1'b0 && reg_rdata[0] == 1'b0)
    else $error("reserved power bits read nonzero");

  reserved_dyn_a: assert property (
    req.rd && req.addr == cep_pkg::DYN_CFG_ADDR
    |=> reg_rvalid && reg_rdata[2] == 1'b0)
    else $error("reserved dynamic bit reads nonzero");

  playback_rise_a: assert property (
    $rose(state.path_power_config[6])
    |=> playback_power == chan_order($past(state.channel_enables[3:0])))
    else $error("playback power-up ignores enables");

  record_follow_a: assert property (
    state.path_power_config[7] && $past(state.path_power_config[7])
    && state.dynamic_power_swap_config[7]
    |=> (record_power & cep_pkg::DYN_NARROW_MASK)
        == (chan_order($past(state.channel_enables[7:4]))
            & cep_pkg::DYN_NARROW_MASK))
    else $error("record channels 1-2 ignore enables in dynamic mode");

  playback_follow_a: assert property (
    state.path_power_config[6] && $past(state.path_power_config[6])
    && state.dynamic_power_swap_config[5]
    |=> (playback_power & cep_pkg::DYN_NARROW_MASK)
        == (chan_order($past(state.channel_enables[3:0]))
            & cep_pkg::DYN_NARROW_MASK))
    else $error("playback channels 1-2 ignore enables in dynamic mode");

  record_wide_a: assert property (
    state.path_power_config[7] && $past(state.path_power_config[7])
    && state.dynamic_power_swap_config[7]
    && state.dynamic_power_swap_config[6]
    |=> record_power == chan_order($past(state.channel_enables[7:4])))
    else $error("record channels ignore enables in wide mode");

  playback_wide_a: assert property (
    state.path_power_config[6] && $past(state.path_power_config[6])
    && state.dynamic_power_swap_config[5]
    && state.dynamic_power_swap_config[4]
    |=> playback_power == chan_order($past(state.channel_enables[3:0])))
    else $error("playback channels ignore enables in wide mode");

  split_clock_a: assert property (
    req.wr && req.addr == cep_pkg::DYN_CFG_ADDR
    |=> dynamic_split_mod_clocks == $past(req.wdata[3]))
    else $error("split clock control not taken from write");

  play_swap_a: assert property (
    req.wr && req.addr == cep_pkg::DYN_CFG_ADDR
    |=> playback_pair_exchange == $past(req.wdata[0]))
    else $error("playback swap not taken from write");

  ultra_write_a: assert property (
    req.wr && req.addr == cep_pkg::PATH_PWR_ADDR
    |=> ultrasonic_detect_on == $past(req.wdata[3]))
    else $error("ultrasonic detection not taken from write");

  ultra_second_a: assert property (
    req.wr && req.addr == cep_pkg::PATH_PWR_ADDR
    |=> ultrasonic_second_detect_on == $past(req.wdata[1]))
    else $error("second ultrasonic detection not taken from write");

  record_up_c: cover property (
    $rose(state.path_power_config[7]) ##1 record_power != 4'h0);
  dynamic_switch_c: cover property (
    state.dynamic_power_swap_config[7] && $changed(record_power)
    && $past(record_power) != 4'h0);
  register_read_c: cover property (
    req.rd && req.addr == cep_pkg::DYN_CFG_ADDR ##1 reg_rvalid);

endmodule // cep_reg_bank

/* File: tb/cep_host_model.sv */
/*
  Host side of the control port: turns register accesses into one-cycle
  read and write strobes with address and data.
  Assumes it is called just at a rising edge of mclk.
*/
`timescale 1ns/1ps

module cep_host_model (
  input  wire logic             mclk,
  output cep_pkg::cep_reg_req_t req
);
  // ****************************************************************
  // Bus driving
  // ****************************************************************
  initial begin
    req = '0;
  end

  // Drives one request just after the edge and holds it to the next edge
  task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, input logic raw);
    logic [7:0] dd;
    dd = d;
    if (!raw && a == 8'h77) begin
      dd[2] = 1'b0;
    end
    if (!raw && a == 8'h78) begin
      dd = dd & 8'hEE;
    end
    #1;
    req.wr    = w;
    req.rd    = r;
    req.addr  = a;
    req.wdata = dd;
    @(posedge mclk);
  endtask

  // Released address and data no longer show the last value
  task automatic idle();
    #1;
    req.wr    = 1'b0;
    req.rd    = 1'b0;
    req.addr  = ~req.addr;
    req.wdata = ~req.wdata;
    @(posedge mclk);
  endtask
endmodule // cep_host_model

/* File: tb/channel_enable_power_config_bench.sv */
/*
  Self-checking bench of the register bank: host model drives requests,
  read results are queued and checked by a monitor, output levels by
  direct comparison against a model of registers 0x77 and 0x78.
  Assumes the bank answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps

module channel_enable_power_config_bench;
  logic                  mclk;
  logic                  nrst;
  cep_pkg::cep_reg_req_t req;
  logic [7:0]            reg_rdata;
  logic                  reg_rvalid;
  logic [3:0]            record_power;
  logic [3:0]            playback_power;
  wire  [6:0]            lv;
  int                    errors;
  int                    cmp_count;
  logic [7:0]            rd_q[$];
  logic [7:0]            m77;
  logic [7:0]            m78;
  logic [7:0]            e;
  int                    bl[7] = '{3, 1, 0, 5, 3, 2, 1};

  cep_host_model i_host (.mclk(mclk), .req(req));

  cep_reg_bank i_dut (
    .mclk                        (mclk),
    .nrst                        (nrst),
    .req                         (req),
    .reg_rdata                   (reg_rdata),
    .reg_rvalid                  (reg_rvalid),
    .record_power                (record_power),
    .playback_power              (playback_power),
    .mic_bias_power_up           (lv[6]),
    .ultrasonic_detect_on        (lv[5]),
    .voice_detect_on             (lv[4]),
    .ultrasonic_second_detect_on (lv[3]),
    .record_pair_exchange        (lv[2]),
    .playback_pair_exchange      (lv[1]),
    .dynamic_split_mod_clocks    (lv[0])
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  always #2 mclk = ~mclk;

  function automatic logic [3:0] rmap(input logic [7:0] v);
    return {v[4], v[5], v[6], v[7]};
  endfunction

  function automatic logic [3:0] pmap(input logic [7:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic raw = 1'b0);
    if (a == 8'h77) m77 = d & 8'hFB;
    if (a == 8'h78) m78 = d & 8'hEE;
    i_host.xfer(1'b1, 1'b0, a, d, raw);
    i_host.idle();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    rd_q.push_back(x);
    i_host.xfer(1'b0, 1'b1, a, 8'h00, 1'b0);
    i_host.idle();
  endtask

  // Compares powers and level outputs after they have settled
  task automatic chk_out(input logic [3:0] rp, input logic [3:0] pp);
    logic [14:0] x;
    repeat (2) @(posedge mclk);
    #1;
    x = {rp, pp, m78[5], m78[3], m78[2], m78[1], m77[1], m77[0], m77[3]};
    cmp_count++;
    if ({record_power, playback_power, lv} !== x) begin
      errors++;
      $display("BAD %0t outputs %h expected %h", $time,
               {record_power, playback_power, lv}, x);
    end
    // Return on a rising edge so the next request starts one step after it
    @(posedge mclk);
  endtask

  task automatic chk_rd();
    logic [7:0] x;
    cmp_count++;
    if (rd_q.size() == 0) begin
      errors++;
      $display("BAD %0t unexpected read answer", $time);
    end else begin
      x = rd_q.pop_front();
      if (reg_rdata !== x) begin
        errors++;
        $display("BAD %0t read %h expected %h", $time, reg_rdata, x);
      end
    end
  endtask

  always @(posedge mclk) begin
    if (nrst === 1'b1 && reg_rvalid === 1'b1) begin
      chk_rd();
    end
  end

  // ****************************************************************
  // Watchdog and tests
  // ****************************************************************
  initial begin
    #40000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    errors = 0;
    cmp_count = 0;
    m77 = 8'h00;
    m78 = 8'h00;
    void'($urandom(32'hF83E7F17));
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
    @(posedge mclk);
    chk_out(4'h0, 4'h0);
    rd(8'h76, 8'hCC);
    rd(8'h77, 8'h00);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h00);
    rd_q.push_back(8'hCC);
    rd_q.push_back(8'h00);
    i_host.xfer(1'b0, 1'b1, 8'h76, 8'h00, 1'b0);
    i_host.xfer(1'b0, 1'b1, 8'h77, 8'h00, 1'b0);
    i_host.idle();
    wr(8'h78, 8'h80);
    chk_out(4'h3, 4'h0);
    wr(8'h78, 8'h40);
    chk_out(4'h0, 4'h3);
    for (int i = 0; i < 8; i++) begin
      e = 8'($urandom);
      wr(8'h76, e);
      wr(8'h78, 8'h00);
      wr(8'h78, 8'hC0);
      chk_out(rmap(e), pmap(e));
      rd(8'h76, e);
    end
    // Enable change with path up and dynamic off must wait for the path to power down and up again
    wr(8'h76, ~e);
    chk_out(rmap(e), pmap(e));
    wr(8'h78, 8'h00);
    chk_out(4'h0, 4'h0);
    wr(8'h78, 8'hC0);
    chk_out(rmap(~e), pmap(~e));
    // Dynamic switching, narrow then wide
    wr(8'h76, 8'h00);
    wr(8'h78, 8'h00);
    wr(8'h78, 8'hC0);
    wr(8'h77, 8'hA0);
    wr(8'h76, 8'hFF);
    chk_out(4'h3, 4'h3);
    wr(8'h77, 8'hF0);
    wr(8'h76, 8'h00);
    wr(8'h76, 8'hFF);
    chk_out(4'hF, 4'hF);
    wr(8'h76, 8'h50);
    chk_out(4'hA, 4'h0);
    // Write and read of one place in one cycle returns the old value
    rd_q.push_back(8'h50);
    i_host.xfer(1'b1, 1'b1, 8'h76, 8'h33, 1'b0);
    i_host.idle();
    rd(8'h76, 8'h33);
    wr(8'h77, 8'h00);
    wr(8'h78, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr((i < 3) ? 8'h77 : 8'h78, 8'h01 << bl[i]);
      chk_out(4'h0, 4'h0);
      wr((i < 3) ? 8'h77 : 8'h78, 8'h00);
    end
    // A careless host setting reserved bits
    wr(8'h77, 8'hFF, 1'b1);
    rd(8'h77, 8'hFB);
    wr(8'h78, 8'hFF, 1'b1);
    rd(8'h78, 8'hEE);
    chk_out(4'hC, 4'hC);
    // Reset in mid-run restores the reset values
    #1;
    nrst = 1'b0;
    @(posedge mclk);
    #1;
    nrst = 1'b1;
    m77 = 8'h00;
    m78 = 8'h00;
    chk_out(4'h0, 4'h0);
    rd(8'h76, 8'hCC);
    repeat (3) @(posedge mclk);
    cmp_count++;
    if (rd_q.size() != 0) begin
      errors++;
      $display("BAD %0t reads left unanswered", $time);
    end
    print_verdict();
  end
endmodule // channel_enable_power_config_bench
